// [src/namur_params.svh]
`ifndef NAMUR_PARAMS_SVH
`define NAMUR_PARAMS_SVH

// Default channel count and channel index width, shared by the register-driven and switch-driven variants.
`define CH_COUNT_DEFAULT    8
`define CH_IDX_W            3

// Settings object subindices.
`define SUB_MAX_INDEX       8'h00
`define SUB_INPUT_KIND      8'h11

// Reset values of the settings object.
`define MAX_SUBINDEX_RESET  8'h11
`define INPUT_KIND_RESET    16'h0014

// Input kind codes.
`define KIND_OFF_CODE       16'h0000
`define KIND_DRY_NO_CODE    16'h000a
`define KIND_DRY_NC_CODE    16'h000b
`define KIND_SENS_NO_CODE   16'h0014
`define KIND_SENS_NC_CODE   16'h0015

// Value returned for a subindex that does not exist.
`define UNMAPPED_RDATA      16'h0000

`endif

// [src/namur_pkg.sv]
`include "namur_params.svh"

package namur_pkg;

  // Input kind selected per channel.
  typedef enum logic [15:0] {
    KIND_OFF     = `KIND_OFF_CODE,
    KIND_DRY_NO  = `KIND_DRY_NO_CODE,
    KIND_DRY_NC  = `KIND_DRY_NC_CODE,
    KIND_SENS_NO = `KIND_SENS_NO_CODE,
    KIND_SENS_NC = `KIND_SENS_NC_CODE
  } input_kind_t;

  // Loop state seen by the current comparators of one channel.
  typedef struct packed {
    logic open;
    logic short_c;
    logic conducting;
  } loop_state_t;

  // Evaluated result of one channel.
  typedef struct packed {
    logic in_val;
    logic err;
  } chan_result_t;

endpackage : namur_pkg

// [src/namur_input_channel_eval.sv]
`timescale 1ns/1ps
`include "namur_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - Open circuit: error set, input off.
// - Short circuit: error set, input on.
// - Non-conducting valid loop: input 0, no error.
// - Conducting valid loop: input 1, no error.
// - Per-channel switch inverts that channel only.
// - Switch off positive, on negative switching.
// - Inverted: short off+error, open on+error.
// - Sixteen-bit kind code selects channel mode.
// - Kind resets to normally-open sensor code.
// - Dry contact modes never flag errors.
// - Dry contact NO direct, NC reversed.
// - Green lamp follows input, red follows error.
// - General lamp lights on supply fault.
module namur_input_channel_eval
  import namur_pkg::*;
#(
  parameter int NUM_CH     = `CH_COUNT_DEFAULT,
  parameter int IDX_W      = `CH_IDX_W,
  parameter bit USE_SWITCH = 1'b0
) (
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // Loop comparators per channel, asynchronous to CLK.
  input  wire logic [NUM_CH-1:0] LOOP_OPEN,
  input  wire logic [NUM_CH-1:0] LOOP_SHORT,
  input  wire logic [NUM_CH-1:0] LOOP_COND,
  // Polarity switches per channel, asynchronous to CLK.
  input  wire logic [NUM_CH-1:0] INVERT_SW,
  // Field supply good level, asynchronous to CLK.
  input  wire logic              SUPPLY_OK,
  // Settings object access.
  input  wire logic              SET_WR,
  input  wire logic              SET_RD,
  input  wire logic [IDX_W-1:0]  SET_CH,
  input  wire logic [7:0]        SET_SUB,
  input  wire logic [15:0]       SET_WDATA,
  output logic      [15:0]       SET_RDATA,
  output logic                   SET_ACK,
  // Process data.
  output logic      [NUM_CH-1:0] IN_VAL,
  output logic      [NUM_CH-1:0] ERR,
  // Indicators.
  output logic      [NUM_CH-1:0] LED_GREEN,
  output logic      [NUM_CH-1:0] LED_RED,
  output logic                   LED_SUPPLY_ERR
);

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation of one channel from its kind, loop state and switch.
  // The same code serves every channel of both variants.

  function automatic chan_result_t eval_chan(
    input logic [15:0] kind,
    input loop_state_t loop,
    input logic        sw
  );
    chan_result_t res;
    logic         inv;
    logic         contact;
    // Locals are set first so that every path leaves them defined.
    res     = '0;
    inv     = 1'b0;
    // A shorted dry contact still counts as a closed contact.
    contact = loop.conducting | loop.short_c;
    // Unknown codes fall through to the default and read as off.
    case (kind)
      `KIND_SENS_NO_CODE, `KIND_SENS_NC_CODE: begin
        // The switch only steers polarity on the switch-driven variant.
        inv = (kind == `KIND_SENS_NC_CODE) | (USE_SWITCH & sw);
        if (loop.open) begin
          // Open wins over short if both comparators fire at once.
          res.err    = 1'b1;
          res.in_val = inv;
        end else if (loop.short_c) begin
          res.err    = 1'b1;
          res.in_val = ~inv;
        end else begin
          res.err    = 1'b0;
          res.in_val = loop.conducting ^ inv;
        end
      end
      `KIND_DRY_NO_CODE: begin
        // Loop faults are not looked at, so no error can arise.
        res.err    = 1'b0;
        res.in_val = contact;
      end
      `KIND_DRY_NC_CODE: begin
        // Same contact sense as above, read the other way round.
        res.err    = 1'b0;
        res.in_val = ~contact;
      end
      default: begin
        // Channel off and codes without meaning report nothing.
        res = '0;
      end
    endcase
    return res;
  endfunction : eval_chan

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for everything arriving from the field side.
  // Reset clears the loop and switch stages and sets the supply stages to good, so that no stale level leaks out after it.

  // Flop stages; a first stage feeds nothing but its second stage.
  logic [NUM_CH-1:0] open_s1;
  logic [NUM_CH-1:0] open_s2;
  logic [NUM_CH-1:0] short_s1;
  logic [NUM_CH-1:0] short_s2;
  logic [NUM_CH-1:0] cond_s1;
  logic [NUM_CH-1:0] cond_s2;
  logic [NUM_CH-1:0] sw_s1;
  logic [NUM_CH-1:0] sw_s2;
  logic              supply_s1;
  logic              supply_s2;

  // Next values of the flop stages.
  logic [NUM_CH-1:0] next_open_s1;
  logic [NUM_CH-1:0] next_open_s2;
  logic [NUM_CH-1:0] next_short_s1;
  logic [NUM_CH-1:0] next_short_s2;
  logic [NUM_CH-1:0] next_cond_s1;
  logic [NUM_CH-1:0] next_cond_s2;
  logic [NUM_CH-1:0] next_sw_s1;
  logic [NUM_CH-1:0] next_sw_s2;
  logic              next_supply_s1;
  logic              next_supply_s2;

  // Supply is assumed good during reset so the lamp stays dark.
  always_comb begin
    next_open_s1   = LOOP_OPEN;
    next_open_s2   = open_s1;
    next_short_s1  = LOOP_SHORT;
    next_short_s2  = short_s1;
    next_cond_s1   = LOOP_COND;
    next_cond_s2   = cond_s1;
    next_sw_s1     = INVERT_SW;
    next_sw_s2     = sw_s1;
    next_supply_s1 = SUPPLY_OK;
    next_supply_s2 = supply_s1;
    // Reset overrides every stage in the same cycle.
    if (!RST_N) begin
      next_open_s1   = '0;
      next_open_s2   = '0;
      next_short_s1  = '0;
      next_short_s2  = '0;
      next_cond_s1   = '0;
      next_cond_s2   = '0;
      next_sw_s1     = '0;
      next_sw_s2     = '0;
      next_supply_s1 = 1'b1;
      next_supply_s2 = 1'b1;
    end
  end

  // Plain registers; all the choices are made in the process above.
  always_ff @(posedge CLK) begin
    open_s1   <= next_open_s1;
    open_s2   <= next_open_s2;
    short_s1  <= next_short_s1;
    short_s2  <= next_short_s2;
    cond_s1   <= next_cond_s1;
    cond_s2   <= next_cond_s2;
    sw_s1     <= next_sw_s1;
    sw_s2     <= next_sw_s2;
    supply_s1 <= next_supply_s1;
    supply_s2 <= next_supply_s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings object: one kind word and one subindex count per channel.
  // Requests come from logic on CLK, so they pass no synchroniser.

  // Stored words per channel and the registered answer.
  logic [15:0] kind_mem      [NUM_CH];
  logic [7:0]  max_sub_mem   [NUM_CH];
  logic [15:0] next_kind     [NUM_CH];
  logic [7:0]  next_max_sub  [NUM_CH];
  logic [15:0] next_rdata;
  logic        next_ack;
  logic        ch_valid;

  // A channel index beyond the fitted count is treated as unmapped.
  assign ch_valid = (32'(SET_CH) < NUM_CH);

  // Writes land on the addressed subindex; a read answers one cycle later.
  always_comb begin
    // By default every stored word keeps its value.
    for (int i = 0; i < NUM_CH; i++) begin
      next_kind[i]    = kind_mem[i];
      next_max_sub[i] = max_sub_mem[i];
    end
    // The read word holds until the next read replaces it.
    next_rdata = SET_RDATA;
    next_ack   = 1'b0;
    // Only two subindices exist; writes to any other are dropped.
    if (SET_WR && ch_valid) begin
      case (SET_SUB)
        `SUB_INPUT_KIND: begin
          next_kind[SET_CH] = SET_WDATA;
        end
        `SUB_MAX_INDEX: begin
          next_max_sub[SET_CH] = SET_WDATA[7:0];
        end
        default: begin
          next_ack = 1'b0;
        end
      endcase
    end
    // A read sees the stored word, not a write made in the same cycle.
    if (SET_RD) begin
      next_ack   = 1'b1;
      next_rdata = `UNMAPPED_RDATA;
      if (ch_valid) begin
        case (SET_SUB)
          `SUB_INPUT_KIND: begin
            next_rdata = kind_mem[SET_CH];
          end
          `SUB_MAX_INDEX: begin
            next_rdata = {8'h00, max_sub_mem[SET_CH]};
          end
          default: begin
            next_rdata = `UNMAPPED_RDATA;
          end
        endcase
      end
    end
    // Every write is answered, even one that is dropped.
    if (SET_WR && !SET_RD) begin
      next_ack = 1'b1;
    end
    // Reset restores the default words on every channel.
    if (!RST_N) begin
      for (int i = 0; i < NUM_CH; i++) begin
        next_kind[i]    = `INPUT_KIND_RESET;
        next_max_sub[i] = `MAX_SUBINDEX_RESET;
      end
      next_rdata = `UNMAPPED_RDATA;
      next_ack   = 1'b0;
    end
  end

  // Registers for the stored words and the answer.
  always_ff @(posedge CLK) begin
    for (int i = 0; i < NUM_CH; i++) begin
      kind_mem[i]    <= next_kind[i];
      max_sub_mem[i] <= next_max_sub[i];
    end
    SET_RDATA <= next_rdata;
    SET_ACK   <= next_ack;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel evaluation and indicators, all straight from flip-flops.
  // Results lag the pins by three edges: two sync stages and this one.

  // Per-channel results and the next values of the outputs.
  chan_result_t      res         [NUM_CH];
  logic [NUM_CH-1:0] next_in_val;
  logic [NUM_CH-1:0] next_err;
  logic [NUM_CH-1:0] next_green;
  logic [NUM_CH-1:0] next_red;
  logic              next_supply_err;

  // The lamps mirror the reported bits, so both lit reads as orange.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      // Each channel reads only its own synchronised pins.
      res[i] = eval_chan(kind_mem[i],
                         '{open:       open_s2[i],
                           short_c:    short_s2[i],
                           conducting: cond_s2[i]},
                         sw_s2[i]);
      next_in_val[i] = res[i].in_val;
      next_err[i]    = res[i].err;
      next_green[i]  = res[i].in_val;
      next_red[i]    = res[i].err;
    end
    // A supply fault lights only the general lamp; channels carry on.
    next_supply_err = ~supply_s2;
    // Reset keeps every lamp dark.
    if (!RST_N) begin
      next_in_val     = '0;
      next_err        = '0;
      next_green      = '0;
      next_red        = '0;
      next_supply_err = 1'b0;
    end
  end

  // Output registers, so that every output comes from a flop.
  always_ff @(posedge CLK) begin
    IN_VAL         <= next_in_val;
    ERR            <= next_err;
    LED_GREEN      <= next_green;
    LED_RED        <= next_red;
    LED_SUPPLY_ERR <= next_supply_err;
  end

endmodule : namur_input_channel_eval

// [sim/namur_sensor_model.sv]
`timescale 1ns/1ps

// Loop states per channel: 0 idle, 1 conducting, 2 open wire, 3 shorted.
module namur_sensor_model #(
  parameter int NUM_CH = 8
) (
  // Requested loop state, two bits per channel.
  input  wire logic [2*NUM_CH-1:0] state,
  // Comparator levels seen by the device.
  output logic      [NUM_CH-1:0]   open,
  output logic      [NUM_CH-1:0]   short_c,
  output logic      [NUM_CH-1:0]   cond
);
  // One comparator at most is high, as on a real loop.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      open[i]    = state[2*i+:2] == 2'h2;
      short_c[i] = state[2*i+:2] == 2'h3;
      cond[i]    = state[2*i+:2] == 2'h1;
    end
  end
endmodule : namur_sensor_model

// [sim/namur_input_channel_eval_checker.sv]
`timescale 1ns/1ps

module namur_input_channel_eval_checker #(
  parameter int NUM_CH = 8
) (
  // Clock, reset and field inputs.
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic [NUM_CH-1:0] LOOP_OPEN,
  input wire logic [NUM_CH-1:0] LOOP_SHORT,
  input wire logic              SUPPLY_OK,
  // Settings access.
  input wire logic              SET_WR,
  input wire logic              SET_RD,
  input wire logic [15:0]       SET_RDATA,
  input wire logic              SET_ACK,
  // Results and lamps.
  input wire logic [NUM_CH-1:0] IN_VAL,
  input wire logic [NUM_CH-1:0] ERR,
  input wire logic [NUM_CH-1:0] LED_GREEN,
  input wire logic [NUM_CH-1:0] LED_RED,
  input wire logic              LED_SUPPLY_ERR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////
  // An error needs an open or short pin seen three edges earlier.
  AST_ERR_CAUSE: assert property (
    (ERR & ~$past(LOOP_OPEN | LOOP_SHORT, 3)) == '0)
    else $error("Error bit without a loop fault.");
  AST_GREEN: assert property (LED_GREEN == IN_VAL)
    else $error("Green lamps differ from input bits.");
  AST_RED: assert property (LED_RED == ERR)
    else $error("Red lamps differ from error bits.");
  AST_ACK_REQ: assert property ((SET_WR || SET_RD) |=> SET_ACK)
    else $error("Settings request not answered.");
  AST_ACK_IDLE: assert property (!(SET_WR || SET_RD) |=> !SET_ACK)
    else $error("Answer without a request.");
  AST_RDATA_HOLD: assert property (!SET_RD |=> $stable(SET_RDATA))
    else $error("Read data moved without a read.");
  AST_SUPPLY_GOOD: assert property (
    SUPPLY_OK [*3] |=> !LED_SUPPLY_ERR)
    else $error("Supply lamp lit on a good supply.");
  AST_SUPPLY_BAD: assert property (
    !SUPPLY_OK [*3] |=> LED_SUPPLY_ERR)
    else $error("Supply lamp dark on a faulty supply.");

  // Main scenarios.
  COV_WR: cover property (SET_WR ##1 SET_ACK);
  COV_RD: cover property (SET_RD ##1 SET_ACK);
  COV_ERR: cover property (|ERR);
  COV_SUPPLY: cover property (LED_SUPPLY_ERR);
endmodule : namur_input_channel_eval_checker

bind namur_input_channel_eval namur_input_channel_eval_checker #(
  .NUM_CH(NUM_CH)) u_checker (
  .CLK(CLK), .RST_N(RST_N), .LOOP_OPEN(LOOP_OPEN), .LOOP_SHORT(LOOP_SHORT),
  .SUPPLY_OK(SUPPLY_OK), .SET_WR(SET_WR), .SET_RD(SET_RD),
  .SET_RDATA(SET_RDATA), .SET_ACK(SET_ACK), .IN_VAL(IN_VAL), .ERR(ERR),
  .LED_GREEN(LED_GREEN), .LED_RED(LED_RED),
  .LED_SUPPLY_ERR(LED_SUPPLY_ERR));

// [sim/namur_input_channel_eval_bench.sv]
`timescale 1ns/1ps
`include "namur_params.svh"

module namur_input_channel_eval_bench
  import namur_pkg::*;
;
  logic        clk, rst_n, set_wr, set_rd, supply, ack, sup_err;
  logic [2:0]  set_ch;
  logic [7:0]  set_sub, inv_sw, lo, ls, lc, in_val, err, grn, red;
  logic [15:0] wdata, rdata, st;
  logic [15:0] kinds [0:7];
  logic [15:0] tbl [0:4];
  int          num_errors, cmp_count, cyc;

  // The switch variant is used so that kinds and switches both count.
  namur_input_channel_eval #(.USE_SWITCH(1'b1)) u_dut (
    .CLK(clk), .RST_N(rst_n), .LOOP_OPEN(lo), .LOOP_SHORT(ls),
    .LOOP_COND(lc), .INVERT_SW(inv_sw), .SUPPLY_OK(supply),
    .SET_WR(set_wr), .SET_RD(set_rd), .SET_CH(set_ch), .SET_SUB(set_sub),
    .SET_WDATA(wdata), .SET_RDATA(rdata), .SET_ACK(ack), .IN_VAL(in_val),
    .ERR(err), .LED_GREEN(grn), .LED_RED(red), .LED_SUPPLY_ERR(sup_err));
  namur_sensor_model u_sensors (
    .state(st), .open(lo), .short_c(ls), .cond(lc));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling; the tests need well under a thousand cycles.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One request; for a read, d is the expected answer.
  task automatic access(input logic w, input logic [2:0] ch,
                        input logic [7:0] sub, input logic [15:0] d);
    @(posedge clk);
    #1;
    set_wr = w;
    set_rd = ~w;
    set_ch = ch;
    set_sub = sub;
    wdata = d;
    @(posedge clk);
    #1;
    set_wr = 1'b0;
    set_rd = 1'b0;
    check({15'h0, ack}, 16'h0001);
    if (!w) check(rdata, d);
  endtask : access

  // State codes: 1 conducting, 3 shorted, so bit 0 is contact closed.
  function automatic logic [1:0] expect_ch(input logic [15:0] k,
                                           input logic [1:0] s,
                                           input logic sw);
    logic inv;
    inv = (k == KIND_SENS_NC) | sw;
    expect_ch = 2'b00;
    if (k == KIND_DRY_NO) expect_ch = {s[0], 1'b0};
    if (k == KIND_DRY_NC) expect_ch = {~s[0], 1'b0};
    if (k == KIND_SENS_NO || k == KIND_SENS_NC) begin
      if (s == 2'h2) expect_ch = {inv, 1'b1};
      else if (s == 2'h3) expect_ch = {~inv, 1'b1};
      else expect_ch = {s[0] ^ inv, 1'b0};
    end
  endfunction : expect_ch

  // Pins take three edges to show; four are waited.
  task automatic eval_chk;
    logic [7:0] ei;
    logic [7:0] ee;
    repeat (4) @(posedge clk);
    #1;
    for (int c = 0; c < 8; c++) begin
      {ei[c], ee[c]} = expect_ch(kinds[c], st[2*c+:2], inv_sw[c]);
    end
    check({8'h00, in_val}, {8'h00, ei});
    check({8'h00, err}, {8'h00, ee});
    check({grn, red}, {ei, ee});
  endtask : eval_chk

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Each loop state meets the switch both off and on.
  initial begin
    tbl = '{KIND_OFF, KIND_DRY_NO, KIND_DRY_NC, KIND_SENS_NO, KIND_SENS_NC};
    {rst_n, set_wr, set_rd, set_ch, set_sub, wdata} = '0;
    {supply, inv_sw, cyc} = {1'b1, 8'hf0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      st[2*i+:2] = 2'(i % 4);
      kinds[i] = `INPUT_KIND_RESET;
    end
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    access(1'b0, 3'h7, `SUB_MAX_INDEX, 16'h0011);
    access(1'b0, 3'h2, `SUB_INPUT_KIND, 16'h0014);
    eval_chk();
    check({15'h0, sup_err}, 16'h0000);
    access(1'b1, 3'h0, 8'h05, 16'h1234);
    access(1'b0, 3'h0, 8'h05, `UNMAPPED_RDATA);
    access(1'b0, 3'h0, `SUB_INPUT_KIND, 16'h0014);
    access(1'b1, 3'h7, `SUB_MAX_INDEX, 16'h0010);
    access(1'b0, 3'h7, `SUB_MAX_INDEX, 16'h0010);
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 8; c++) begin
        kinds[c] = (k < 5) ? tbl[k] : tbl[c % 5];
        access(1'b1, 3'(c), `SUB_INPUT_KIND, kinds[c]);
      end
      access(1'b0, 3'h7, `SUB_INPUT_KIND, kinds[7]);
      eval_chk();
    end
    inv_sw = 8'h0f;
    eval_chk();
    supply = 1'b0;
    repeat (4) @(posedge clk);
    #1 check({15'h0, sup_err}, 16'h0001);
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    access(1'b0, 3'h5, `SUB_INPUT_KIND, 16'h0014);
    access(1'b0, 3'h7, `SUB_MAX_INDEX, 16'h0011);
    report_and_stop();
  end
endmodule : namur_input_channel_eval_bench
